/* File: rtl/evt_pkg.sv */
// constants shared by the eight bit event timer
package evt_pkg;
  // ****************************************************************
  // widths and register offsets
  // ****************************************************************
  localparam int          CNT_W      = 8;
  localparam int          ADDR_W     = 3;
  localparam int          PRE_W      = 7;
  localparam logic [2:0]  OFF_CTRL0  = 3'h0;
  localparam logic [2:0]  OFF_CTRL1  = 3'h1;
  localparam logic [2:0]  OFF_STATUS = 3'h2;
  localparam logic [2:0]  OFF_COUNT  = 3'h3;
  localparam logic [2:0]  OFF_CMP_A  = 3'h4;
  localparam logic [2:0]  OFF_CMP_B  = 3'h5;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // ctrl0: [7:5] irq enables b,a,wrap  [4:3] clear select  [2:0] clock
  localparam int IRQ_EN_HI  = 7;
  localparam int IRQ_EN_LO  = 5;
  localparam int CLR_HI     = 4;
  localparam int CLR_LO     = 3;
  localparam int CKS_HI     = 2;
  localparam int CKS_LO     = 0;
  // ctrl1: [4:3] trigger edge  [2] trigger enable  [1:0] ext clock edge
  localparam int TEDGE_HI   = 4;
  localparam int TEDGE_LO   = 3;
  localparam int TRG_EN_BIT = 2;
  localparam int XEDGE_HI   = 1;
  localparam int XEDGE_LO   = 0;
  // status: [7:5] flags b,a,wrap  [4] reads one  [3:2] out b  [1:0] out a
  localparam int FLAG_HI    = 7;
  localparam int FLAG_LO    = 5;
  localparam int RSVD_BIT   = 4;
  localparam int OSB_HI     = 3;
  localparam int OSB_LO     = 2;
  localparam int OSA_HI     = 1;
  localparam int OSA_LO     = 0;
  localparam int FLG_WRAP   = 0;
  localparam int FLG_A      = 1;
  localparam int FLG_B      = 2;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [2:0] CKS_STOP = 3'h0;
  localparam logic [2:0] CKS_EXT  = 3'h7;
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A    = 2'h1;
  localparam logic [1:0] CLR_B    = 2'h2;
  localparam logic [1:0] CLR_EXT  = 2'h3;
  localparam logic [1:0] OUT_KEEP = 2'h0;
  localparam logic [1:0] OUT_LOW  = 2'h1;
  localparam logic [1:0] OUT_HIGH = 2'h2;
  localparam logic [1:0] OUT_TGL  = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] XEDGE_RISE = 2'h0;
  localparam logic [1:0] XEDGE_FALL = 2'h1;

  // ****************************************************************
  // reset values and fixed numbers
  // ****************************************************************
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_ZERO   = 8'h00;
  localparam logic [7:0] CMP_RST    = 8'hFF;
  localparam logic [7:0] REG_ZERO   = 8'h00;
  localparam logic [7:0] CNT_ONE    = 8'h01;
  localparam logic [7:0] PRE_SHIFT  = 8'h02;
  localparam int         PIN_EXT    = 0;
  localparam int         PIN_RST    = 1;
  localparam int         PIN_TRG    = 2;
  localparam int         NUM_PINS   = 3;

  typedef enum logic {EVT_RUN, EVT_HALT} evt_run_t;
endpackage : evt_pkg

/* File: rtl/evt_edge.sv */
// synchroniser and edge detector for one timer input pin
`timescale 1ns/10ps
module evt_edge (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  logic meta_d;
  logic sync_d;
  logic last_d;

  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    last_d = sync_q;
  end

  // meta_q feeds sync_q only; edges are taken from the settled pair
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else if (ce) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule : evt_edge

/* File: rtl/evt_timer.sv */
// eight bit event timer with two compare registers and a pulse output
// What this block does
// - count only once a clock source is selected; stay stopped otherwise
// - external clock in both-edge mode counts every rise and every fall
// - wrap from all ones to zero sets the wrap flag
// - wrap flag with its enable set raises the interrupt
// - counter compared against both compare values; match sets its flag
// - match pulse comes in the last cycle the values are equal
// - match flag with its enable set raises the interrupt
// - each match drives the pulse pin by its own two-bit action field
// - clear select 01 or 10 clears the counter on that match
// - clear select 11 clears the counter on a counter reset pin rise
// - with trigger enable, any clear also halts counting at zero
// - halted counter restarts on the selected trigger pin edge
// - action codes: keep, drive low, drive high, toggle
// - a flag clears by writing zero only after it was read as one
// - trigger edge may be rising, falling or both
// - internal clocks are the system clock over 128,64,32,16,8 or 4
`timescale 1ns/10ps
module evt_timer (
  input  wire logic                       mclk,
  input  wire logic                       arst_n,
  input  wire logic                       ce,
  input  wire logic [evt_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  input  wire logic                       ext_clk_pin,
  input  wire logic                       counter_reset_pin,
  input  wire logic                       trigger_input_pin,
  output logic      [7:0]                 rdata,
  output logic                            irq,
  output logic                            pulse_output_pin
);
  // ****************************************************************
  // reset release and pin synchronisers
  // ****************************************************************
  logic       rst_meta_q;
  logic       rst_n;
  logic [2:0] pins;
  logic [2:0] ev_rise;
  logic [2:0] ev_fall;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  assign pins = {trigger_input_pin, counter_reset_pin, ext_clk_pin};

  genvar gi;
  generate
    for (gi = 0; gi < evt_pkg::NUM_PINS; gi++) begin : g_pin
      evt_edge u_edge (
        .mclk (mclk),
        .rst_n(rst_n),
        .ce   (ce),
        .pin  (pins[gi]),
        .rise (ev_rise[gi]),
        .fall (ev_fall[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]             ctrl0_q, ctrl0_d;
  logic [7:0]             ctrl1_q, ctrl1_d;
  logic [3:0]             osel_q, osel_d;
  logic [2:0]             flags_q, flags_d;
  logic [2:0]             seen_q, seen_d;
  logic [7:0]             cnt_q, cnt_d;
  logic [7:0]             cmp_a_q, cmp_a_d;
  logic [7:0]             cmp_b_q, cmp_b_d;
  logic [evt_pkg::PRE_W-1:0] pre_q, pre_d;
  evt_pkg::evt_run_t      run_q, run_d;
  logic                   pin_q, pin_d;
  logic                   irq_q, irq_d;
  logic [7:0]             rdata_q, rdata_d;

  // ****************************************************************
  // decoded fields and events
  // ****************************************************************
  logic [2:0] cks;
  logic [1:0] clr_sel;
  logic [1:0] tedge;
  logic [1:0] xedge;
  logic       trg_en;
  logic [7:0] pre_mask;
  logic       src_tick;
  logic       tick;
  logic       match_a;
  logic       match_b;
  logic       clr_evt;
  logic       wrap_evt;
  logic       trg_hit;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic       wr_stat;
  logic [7:0] status_rd;

  always_comb begin
    cks      = ctrl0_q[evt_pkg::CKS_HI:evt_pkg::CKS_LO];
    clr_sel  = ctrl0_q[evt_pkg::CLR_HI:evt_pkg::CLR_LO];
    tedge    = ctrl1_q[evt_pkg::TEDGE_HI:evt_pkg::TEDGE_LO];
    xedge    = ctrl1_q[evt_pkg::XEDGE_HI:evt_pkg::XEDGE_LO];
    trg_en   = ctrl1_q[evt_pkg::TRG_EN_BIT];
    // codes 1..6 give divide by 4..128
    pre_mask = (evt_pkg::PRE_SHIFT << cks) - evt_pkg::CNT_ONE;
    if (cks == evt_pkg::CKS_STOP) begin
      src_tick = 1'b0;
    end else if (cks == evt_pkg::CKS_EXT) begin
      unique case (xedge)
        evt_pkg::XEDGE_RISE: src_tick = ev_rise[evt_pkg::PIN_EXT];
        evt_pkg::XEDGE_FALL: src_tick = ev_fall[evt_pkg::PIN_EXT];
        default: src_tick = ev_rise[evt_pkg::PIN_EXT] |
                            ev_fall[evt_pkg::PIN_EXT];
      endcase
    end else begin
      src_tick = &(pre_q | ~pre_mask[evt_pkg::PRE_W-1:0]);
    end
    tick     = src_tick && (run_q == evt_pkg::EVT_RUN);
    // the match counts only on the cycle the counter leaves the value
    match_a  = tick && (cnt_q == cmp_a_q);
    match_b  = tick && (cnt_q == cmp_b_q);
    // the reset pin pulse must span at least one sampling edge
    clr_evt  = (match_a && clr_sel == evt_pkg::CLR_A) ||
               (match_b && clr_sel == evt_pkg::CLR_B) ||
               (ev_rise[evt_pkg::PIN_RST] &&
                clr_sel == evt_pkg::CLR_EXT);
    wrap_evt = tick && (cnt_q == evt_pkg::CNT_MAX) && !clr_evt;
    unique case (tedge)
      evt_pkg::EDGE_RISE: trg_hit = ev_rise[evt_pkg::PIN_TRG];
      evt_pkg::EDGE_FALL: trg_hit = ev_fall[evt_pkg::PIN_TRG];
      evt_pkg::EDGE_BOTH: trg_hit = ev_rise[evt_pkg::PIN_TRG] |
                                    ev_fall[evt_pkg::PIN_TRG];
      default:            trg_hit = 1'b0;
    endcase
    wr_stat  = wr_en && (addr == evt_pkg::OFF_STATUS);
    flag_set = {match_b, match_a, wrap_evt};
    flag_clr = wr_stat ? (seen_q & ~wdata[evt_pkg::FLAG_HI:evt_pkg::FLAG_LO])
                       : 3'h0;
    status_rd = {flags_q, 1'b1, osel_q};
  end

  // ****************************************************************
  // counter, prescaler, run state and output pin
  // ****************************************************************
  always_comb begin
    pre_d = pre_q + 7'h01;
    cnt_d = cnt_q;
    if (clr_evt) begin
      cnt_d = evt_pkg::CNT_ZERO;
    end else if (wr_en && addr == evt_pkg::OFF_COUNT) begin
      cnt_d = wdata;
    end else if (tick) begin
      cnt_d = cnt_q + evt_pkg::CNT_ONE;
    end
    run_d = run_q;
    unique case (run_q)
      evt_pkg::EVT_RUN: begin
        if (trg_en && clr_evt) begin
          run_d = evt_pkg::EVT_HALT;
        end
      end
      evt_pkg::EVT_HALT: begin
        if (trg_hit || !trg_en) begin
          run_d = evt_pkg::EVT_RUN;
        end
      end
    endcase
    // match b first so that match a's action applies on top of it when both land together
    pin_d = pin_q;
    if (match_b) begin
      unique case (osel_q[evt_pkg::OSB_HI:evt_pkg::OSB_LO])
        evt_pkg::OUT_KEEP: pin_d = pin_d;
        evt_pkg::OUT_LOW:  pin_d = 1'b0;
        evt_pkg::OUT_HIGH: pin_d = 1'b1;
        evt_pkg::OUT_TGL:  pin_d = ~pin_d;
      endcase
    end
    if (match_a) begin
      unique case (osel_q[evt_pkg::OSA_HI:evt_pkg::OSA_LO])
        evt_pkg::OUT_KEEP: pin_d = pin_d;
        evt_pkg::OUT_LOW:  pin_d = 1'b0;
        evt_pkg::OUT_HIGH: pin_d = 1'b1;
        evt_pkg::OUT_TGL:  pin_d = ~pin_d;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
      cnt_q <= evt_pkg::CNT_ZERO;
      run_q <= evt_pkg::EVT_RUN;
      pin_q <= 1'b0;
    end else if (ce) begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      pin_q <= pin_d;
    end
  end

  // ****************************************************************
  // register port, flags and interrupt
  // ****************************************************************
  always_comb begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    osel_d  = osel_q;
    cmp_a_d = cmp_a_q;
    cmp_b_d = cmp_b_q;
    seen_d  = seen_q;
    rdata_d = evt_pkg::REG_ZERO;
    if (wr_en) begin
      unique case (addr)
        evt_pkg::OFF_CTRL0:  ctrl0_d = wdata;
        evt_pkg::OFF_CTRL1:  ctrl1_d = wdata;
        evt_pkg::OFF_STATUS: osel_d  = wdata[evt_pkg::OSB_HI:evt_pkg::OSA_LO];
        evt_pkg::OFF_CMP_A:  cmp_a_d = wdata;
        evt_pkg::OFF_CMP_B:  cmp_b_d = wdata;
        default: ;
      endcase
      if (wr_stat) begin
        seen_d = 3'h0;
      end
    end
    if (rd_en) begin
      unique case (addr)
        evt_pkg::OFF_CTRL0:  rdata_d = ctrl0_q;
        evt_pkg::OFF_CTRL1:  rdata_d = ctrl1_q;
        evt_pkg::OFF_STATUS: begin
          rdata_d = status_rd;
          seen_d  = seen_q | flags_q;
        end
        evt_pkg::OFF_COUNT:  rdata_d = cnt_q;
        evt_pkg::OFF_CMP_A:  rdata_d = cmp_a_q;
        evt_pkg::OFF_CMP_B:  rdata_d = cmp_b_q;
        default:             rdata_d = evt_pkg::REG_ZERO;
      endcase
    end
    // a new event in the clearing cycle survives the clear
    flags_d = (flags_q & ~flag_clr) | flag_set;
    irq_d   = |(flags_q & ctrl0_q[evt_pkg::IRQ_EN_HI:evt_pkg::IRQ_EN_LO]);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_q <= evt_pkg::REG_ZERO;
      ctrl1_q <= evt_pkg::REG_ZERO;
      osel_q  <= 4'h0;
      cmp_a_q <= evt_pkg::CMP_RST;
      cmp_b_q <= evt_pkg::CMP_RST;
      flags_q <= 3'h0;
      seen_q  <= 3'h0;
      irq_q   <= 1'b0;
      rdata_q <= evt_pkg::REG_ZERO;
    end else if (ce) begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      osel_q  <= osel_d;
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
      flags_q <= flags_d;
      seen_q  <= seen_d;
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata            = rdata_q;
  assign irq              = irq_q;
  assign pulse_output_pin = pin_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_clr_halt;
    ce && trg_en && clr_evt && run_q == evt_pkg::EVT_RUN;
  endsequence
  sequence s_halted_zero;
    run_q == evt_pkg::EVT_HALT && cnt_q == evt_pkg::CNT_ZERO;
  endsequence

  property p_stopped;
    ce && cks == evt_pkg::CKS_STOP && !clr_evt &&
      !(wr_en && addr == evt_pkg::OFF_COUNT) |=> $stable(cnt_q);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved with no clock source");

  property p_both_edges;
    cks == evt_pkg::CKS_EXT && xedge[1] && run_q == evt_pkg::EVT_RUN &&
      ev_fall[evt_pkg::PIN_EXT] |-> tick;
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("falling external edge did not count");

  property p_wrap;
    ce && tick && cnt_q == evt_pkg::CNT_MAX && !clr_evt &&
      !(wr_en && addr == evt_pkg::OFF_COUNT)
      |=> flags_q[evt_pkg::FLG_WRAP] && cnt_q == evt_pkg::CNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap did not set its flag");

  property p_irq_wrap;
    ce && flags_q[evt_pkg::FLG_WRAP] && ctrl0_q[evt_pkg::IRQ_EN_LO] |=> irq;
  endproperty
  a_irq_wrap: assert property (p_irq_wrap)
    else $error("enabled wrap flag gave no interrupt");

  property p_match_last;
    ce && match_b && clr_sel != evt_pkg::CLR_B && !clr_evt
      |=> flags_q[evt_pkg::FLG_B] && cnt_q != $past(cnt_q);
  endproperty
  a_match_last: assert property (p_match_last)
    else $error("match b flag not set as the value was left");

  property p_irq_none;
    ce && !(|(flags_q & ctrl0_q[evt_pkg::IRQ_EN_HI:evt_pkg::IRQ_EN_LO]))
      |=> !irq;
  endproperty
  a_irq_none: assert property (p_irq_none)
    else $error("interrupt with no enabled flag");

  property p_out_high;
    ce && match_a && osel_q[evt_pkg::OSA_HI:evt_pkg::OSA_LO] ==
      evt_pkg::OUT_HIGH |=> pulse_output_pin;
  endproperty
  a_out_high: assert property (p_out_high)
    else $error("match a did not drive the pin high");

  property p_clr_a;
    ce && match_a && clr_sel == evt_pkg::CLR_A |=> cnt_q == evt_pkg::CNT_ZERO;
  endproperty
  a_clr_a: assert property (p_clr_a)
    else $error("match a did not clear the counter");

  property p_clr_ext;
    ce && ev_rise[evt_pkg::PIN_RST] && clr_sel == evt_pkg::CLR_EXT
      |=> cnt_q == evt_pkg::CNT_ZERO;
  endproperty
  a_clr_ext: assert property (p_clr_ext)
    else $error("reset pin rise did not clear the counter");

  property p_halt;
    s_clr_halt |=> s_halted_zero;
  endproperty
  a_halt: assert property (p_halt)
    else $error("trigger mode clear did not halt at zero");

  property p_resume;
    ce && run_q == evt_pkg::EVT_HALT && trg_hit |=> run_q == evt_pkg::EVT_RUN;
  endproperty
  a_resume: assert property (p_resume)
    else $error("trigger edge did not restart counting");

  property p_clear_guard;
    ce && wr_stat && !seen_q[evt_pkg::FLG_A] && flags_q[evt_pkg::FLG_A]
      |=> flags_q[evt_pkg::FLG_A];
  endproperty
  a_clear_guard: assert property (p_clear_guard)
    else $error("unread flag was cleared");
endmodule : evt_timer

/* File: verif/tb.sv */
// self-checking testbench for the eight bit event timer
`timescale 1ns/10ps
module tb;
  // ****************************************************************
  // clock, reset and design hookup
  // ****************************************************************
  logic       mclk;
  logic       arst_n;
  logic       ce;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr_en;
  logic       rd_en;
  logic       ext_clk_pin;
  logic       counter_reset_pin;
  logic       trigger_input_pin;
  logic [7:0] rdata;
  logic       irq;
  logic       pulse_output_pin;
  int         miscompares;
  int         n_compared;
  logic [7:0] rd_val;

  evt_timer u_evt_timer (
    .mclk              (mclk),
    .arst_n            (arst_n),
    .ce                (ce),
    .addr              (addr),
    .wdata             (wdata),
    .wr_en             (wr_en),
    .rd_en             (rd_en),
    .ext_clk_pin       (ext_clk_pin),
    .counter_reset_pin (counter_reset_pin),
    .trigger_input_pin (trigger_input_pin),
    .rdata             (rdata),
    .irq               (irq),
    .pulse_output_pin  (pulse_output_pin)
  );

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // ****************************************************************
  // bus, compare and wait helpers
  // ****************************************************************
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk8(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [2:0] a);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    rd_val = rdata;
  endtask : reg_rd

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  // sel 0 watches irq, sel 1 the pulse pin; bounded so a hang cannot stall
  task automatic wait_for(input int sel, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge mclk);
      #1;
      if ((sel == 0 ? irq : pulse_output_pin) === v)
        return;
    end
    miscompares++;
    $display("mismatch wait_for sel %0d expected %b seen timeout", sel, v);
    complete_run();
  endtask : wait_for

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_values;
    reg_rd(evt_pkg::OFF_CTRL0);
    chk8("ctrl0", 8'h00, rd_val);
    reg_rd(evt_pkg::OFF_STATUS);
    chk8("status", 8'h10, rd_val);
    reg_rd(evt_pkg::OFF_CMP_A);
    chk8("cmp_a", 8'hFF, rd_val);
    reg_rd(3'h6);
    chk8("unmapped", 8'h00, rd_val);
    idle(20);
    reg_rd(evt_pkg::OFF_COUNT);
    chk8("count_stopped", 8'h00, rd_val);
  endtask : t_reset_values

  task automatic t_wrap;
    logic [7:0] c;
    reg_wr(evt_pkg::OFF_COUNT, 8'hFE);
    reg_wr(evt_pkg::OFF_CTRL0, 8'h21);
    wait_for(0, 1'b1, 40);
    reg_wr(evt_pkg::OFF_CTRL0, 8'h00);
    reg_rd(evt_pkg::OFF_COUNT);
    c = rd_val;
    idle(20);
    reg_rd(evt_pkg::OFF_COUNT);
    chk8("count_held", c, rd_val);
    reg_wr(evt_pkg::OFF_STATUS, 8'h00);
    reg_rd(evt_pkg::OFF_STATUS);
    // both compare values rest at all ones, so the wrap tick matches too
    chk8("status_unread_clear", 8'hF0, rd_val);
    reg_wr(evt_pkg::OFF_STATUS, 8'h00);
    reg_rd(evt_pkg::OFF_STATUS);
    chk8("status_cleared", 8'h10, rd_val);
    idle(2);
    chk8("irq_dropped", 8'h00, {7'h00, irq});
  endtask : t_wrap

  task automatic t_match_a;
    int         i;
    logic [7:0] mx;
    mx = 8'h00;
    reg_wr(evt_pkg::OFF_COUNT, 8'h00);
    reg_wr(evt_pkg::OFF_CMP_A, 8'h03);
    reg_wr(evt_pkg::OFF_STATUS, 8'h03);
    reg_wr(evt_pkg::OFF_CTRL0, 8'h49);
    wait_for(1, 1'b1, 40);
    // the interrupt follows the flag one cycle later
    @(posedge mclk);
    #1;
    chk8("irq_match_a", 8'h01, {7'h00, irq});
    wait_for(1, 1'b0, 40);
    for (i = 0; i < 12; i++) begin
      reg_rd(evt_pkg::OFF_COUNT);
      if (rd_val > mx)
        mx = rd_val;
    end
    chk8("count_max_clear_a", 8'h03, mx);
    reg_wr(evt_pkg::OFF_CTRL0, 8'h08);
    idle(3);
    chk8("irq_masked", 8'h00, {7'h00, irq});
    reg_rd(evt_pkg::OFF_STATUS);
    chk8("status_match_a", 8'h53, rd_val);
    reg_wr(evt_pkg::OFF_STATUS, 8'h00);
    reg_rd(evt_pkg::OFF_STATUS);
    chk8("status_a_cleared", 8'h10, rd_val);
  endtask : t_match_a

  task automatic t_out_codes;
    int         i;
    logic [7:0] mx;
    mx = 8'h00;
    reg_wr(evt_pkg::OFF_COUNT, 8'h00);
    reg_wr(evt_pkg::OFF_CMP_A, 8'h02);
    reg_wr(evt_pkg::OFF_CMP_B, 8'h05);
    reg_wr(evt_pkg::OFF_STATUS, 8'h06);
    reg_wr(evt_pkg::OFF_CTRL0, 8'h92);
    // three waits: the pin level left by the last scenario is not known
    wait_for(1, 1'b1, 60);
    wait_for(1, 1'b0, 60);
    wait_for(1, 1'b1, 60);
    for (i = 0; i < 20; i++) begin
      reg_rd(evt_pkg::OFF_COUNT);
      if (rd_val > mx)
        mx = rd_val;
    end
    chk8("count_max_clear_b", 8'h05, mx);
    chk8("irq_match_b", 8'h01, {7'h00, irq});
    reg_wr(evt_pkg::OFF_CTRL0, 8'h00);
    reg_rd(evt_pkg::OFF_STATUS);
    chk8("status_match_ab", 8'hD6, rd_val);
    reg_wr(evt_pkg::OFF_STATUS, 8'h00);
  endtask : t_out_codes

  task automatic t_ext_both;
    reg_wr(evt_pkg::OFF_CTRL0, 8'h00);
    reg_wr(evt_pkg::OFF_COUNT, 8'h00);
    reg_wr(evt_pkg::OFF_CTRL1, 8'h02);
    reg_wr(evt_pkg::OFF_CTRL0, 8'h07);
    repeat (6) begin
      @(posedge mclk);
      ext_clk_pin <= ~ext_clk_pin;
      idle(4);
    end
    idle(4);
    reg_wr(evt_pkg::OFF_CTRL0, 8'h00);
    reg_rd(evt_pkg::OFF_COUNT);
    chk8("count_both_edges", 8'h06, rd_val);
  endtask : t_ext_both

  task automatic t_trigger;
    reg_wr(evt_pkg::OFF_CTRL1, 8'h0C);
    reg_wr(evt_pkg::OFF_CTRL0, 8'h19);
    idle(20);
    @(posedge mclk);
    counter_reset_pin <= 1'b1;
    idle(3);
    counter_reset_pin <= 1'b0;
    idle(10);
    reg_rd(evt_pkg::OFF_COUNT);
    chk8("count_after_reset_pin", 8'h00, rd_val);
    idle(30);
    reg_rd(evt_pkg::OFF_COUNT);
    chk8("count_halted", 8'h00, rd_val);
    @(posedge mclk);
    trigger_input_pin <= 1'b1;
    idle(30);
    reg_rd(evt_pkg::OFF_COUNT);
    chk8("count_restarted", 8'h01, {7'h00, rd_val != 8'h00});
  endtask : t_trigger

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    miscompares       = 0;
    n_compared        = 0;
    arst_n            = 1'b0;
    ce                = 1'b1;
    addr              = 3'h0;
    wdata             = 8'h00;
    wr_en             = 1'b0;
    rd_en             = 1'b0;
    ext_clk_pin       = 1'b0;
    counter_reset_pin = 1'b0;
    trigger_input_pin = 1'b0;
    idle(10);
    arst_n <= 1'b1;
    idle(4);
    t_reset_values();
    t_wrap();
    t_match_a();
    t_out_codes();
    t_ext_both();
    t_trigger();
    complete_run();
  end
endmodule : tb
